/* core/mig_pkg.sv */
// constants, field layout and state types of the multi-input logic gate
// assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock
package mig_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_SWIN = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_INPUTS = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_SEL_W = 8;
  localparam int CFG_CNT_LSB = 8;
  localparam int CFG_CNT_W = 4;
  localparam int ST_RESULT_BIT = 0;
  localparam int ST_ECHO_BIT = 1;
  localparam int ST_CNT_BAD_BIT = 2;
  localparam int ST_SEL_BAD_BIT = 3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0200;
  localparam logic [31:0] SWIN_RESET = 32'h0000_0000;

  // ----------------------------------------
  // function codes and input limits
  // ----------------------------------------
  localparam logic [7:0] FN_AND = 8'h00;
  localparam logic [7:0] FN_OR = 8'h01;
  localparam logic [7:0] FN_XOR = 8'h02;
  localparam logic [7:0] FN_NAND = 8'h03;
  localparam logic [7:0] FN_NOR = 8'h04;
  localparam logic [7:0] FN_NXOR = 8'h05;
  localparam int NUM_INPUTS = 14;
  localparam logic [3:0] IN_MIN = 4'h2;
  localparam logic [3:0] IN_MAX = 4'he;

  // ----------------------------------------
  // bus responses and state machines
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } mig_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } mig_rd_state_t;

endpackage : mig_pkg

/* core/mig_eval.sv */
// combinational evaluator: selected boolean function over the active inputs
// assumes the caller registers its outputs
`timescale 1ns/100ps
module mig_eval #(
  parameter int N = 14,
  parameter int SEL_W = 8,
  parameter int CNT_W = 4
) (
  // operands
  input wire logic [N-1:0] bits,
  input wire logic [CNT_W-1:0] count,
  // configuration
  input wire logic [SEL_W-1:0] sel,
  input wire logic enable,
  // results
  output logic next_result,
  output logic next_echo
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [N-1:0] active_mask(input logic [CNT_W-1:0] cnt);
    logic [N-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++) begin
      m[i] = (i < int'(cnt));
    end
    return m;
  endfunction : active_mask

  logic [N-1:0] mask;
  logic and_all;
  logic or_any;
  logic parity;
  logic sel_ok;

  // ----------------------------------------
  // reductions
  // ----------------------------------------
  // RULE14 unused inputs masked
  assign mask = active_mask(count);
  // RULE3 RULE10 reduce across bits
  assign and_all = &(bits | ~mask);
  assign or_any = |(bits & mask);
  assign parity = ^(bits & mask);
  assign sel_ok = (sel <= SEL_W'(mig_pkg::FN_NXOR));

  // ----------------------------------------
  // function select
  // ----------------------------------------
  // RULE1 six operations
  always_comb begin
    next_result = 1'b0;
    unique case (sel)
      // RULE4 and
      SEL_W'(mig_pkg::FN_AND): next_result = and_all;
      // RULE5 or
      SEL_W'(mig_pkg::FN_OR): next_result = or_any;
      // RULE6 xor as parity
      SEL_W'(mig_pkg::FN_XOR): next_result = parity;
      // RULE7 inverted and
      SEL_W'(mig_pkg::FN_NAND): next_result = ~and_all;
      // RULE8 inverted or
      SEL_W'(mig_pkg::FN_NOR): next_result = ~or_any;
      // RULE9 inverted xor
      SEL_W'(mig_pkg::FN_NXOR): next_result = ~parity;
      // RULE12 illegal selector zero
      default: next_result = 1'b0;
    endcase
    // RULE11 disabled forces zero
    if (!enable) begin
      next_result = 1'b0;
    end
  end

  // RULE13 echo follows enable
  assign next_echo = enable & sel_ok;

endmodule : mig_eval

/* core/mig_core.sv */
// multi_input_logic_gate: AXI4-Lite slave, configuration registers and
// registered gate outputs
// assumes logic_input comes from logic on the same clock
//
// Behaviour
// RULE1: six selectable operations: and, nand, or, nor, xor, nxor.
// RULE2: software keeps input count between two and fourteen.
// RULE3: each active input is one bit; result is a single bit.
// RULE4: selector 0 gives and of active inputs.
// RULE5: selector 1 gives or of active inputs.
// RULE6: selector 2 gives exclusive or of active inputs.
// RULE7: selector 3 gives inverted and.
// RULE8: selector 4 gives inverted or.
// RULE9: selector 5 gives inverted exclusive or.
// RULE10: operations extend to fourteen inputs; xor is odd parity.
// RULE11: enable low holds result at zero.
// RULE12: selector above five forces result and echo to zero.
// RULE13: echo follows enable for selector zero to five, else zero.
// RULE14: inputs above the configured count never affect the result.
// RULE15: outputs registered each cycle; synchronous clear zeroes both.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module mig_core #(
  parameter int ADDR_W = 8,
  parameter int N = mig_pkg::NUM_INPUTS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // gate inputs
  input wire logic [N-1:0] logic_input,
  // gate outputs
  output logic result,
  output logic enable_echo
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one-hot register select, order ctrl, config, swin, status, inputs
  function automatic logic [4:0] reg_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    reg_hit = '0;
    reg_hit[0] = (w == mig_pkg::OFF_CTRL);
    reg_hit[1] = (w == mig_pkg::OFF_CONFIG);
    reg_hit[2] = (w == mig_pkg::OFF_SWIN);
    reg_hit[3] = (w == mig_pkg::OFF_STATUS);
    reg_hit[4] = (w == mig_pkg::OFF_INPUTS);
    if (ADDR_W > 8) begin
      if (|(a >> 8)) begin
        reg_hit = '0;
      end
    end
  endfunction : reg_hit

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  mig_pkg::mig_wr_state_t wr_state;
  mig_pkg::mig_rd_state_t rd_state;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_commit;
  logic [4:0] wr_hit;
  logic [4:0] rd_hit;
  logic [31:0] ctrl;
  logic [31:0] config_word;
  logic [31:0] swin;
  logic clr_pulse;
  logic [31:0] next_ctrl;
  logic [N-1:0] applied;
  logic [mig_pkg::CFG_SEL_W-1:0] sel;
  logic [mig_pkg::CFG_CNT_W-1:0] count;
  logic gate_enable;
  logic next_result;
  logic next_echo;
  logic count_bad;
  logic sel_bad;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // ----------------------------------------
  // configuration fields
  // ----------------------------------------
  assign sel = config_word[mig_pkg::CFG_SEL_LSB +: mig_pkg::CFG_SEL_W];
  assign count = config_word[mig_pkg::CFG_CNT_LSB +: mig_pkg::CFG_CNT_W];
  assign gate_enable = ctrl[mig_pkg::CTRL_EN_BIT];
  // software inputs let a test drive the gate without the port
  assign applied = ctrl[mig_pkg::CTRL_SRC_BIT] ? swin[N-1:0] : logic_input;
  // RULE2 count kept in range by software; only flagged here
  assign count_bad = (count < mig_pkg::IN_MIN) || (count > mig_pkg::IN_MAX);
  assign sel_bad = (sel > mig_pkg::FN_NXOR);

  // ----------------------------------------
  // evaluator
  // ----------------------------------------
  mig_eval #(
    .N(N),
    .SEL_W(mig_pkg::CFG_SEL_W),
    .CNT_W(mig_pkg::CFG_CNT_W)
  ) u_eval (
    .bits(applied),
    .count(count),
    .sel(sel),
    .enable(gate_enable),
    .next_result(next_result),
    .next_echo(next_echo)
  );

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // RULE15 result registered, cleared synchronously
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= 1'b0;
    end else if (clr_pulse) begin
      result <= 1'b0;
    end else begin
      result <= next_result;
    end
  end

  // RULE15 echo registered, cleared synchronously
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_echo <= 1'b0;
    end else if (clr_pulse) begin
      enable_echo <= 1'b0;
    end else begin
      enable_echo <= next_echo;
    end
  end

  // ----------------------------------------
  // write channel capture
  // ----------------------------------------
  // address and data are taken in either order and held until both are here
  assign s_axi_awready = (wr_state == mig_pkg::WR_IDLE) && !aw_held;
  assign s_axi_wready = (wr_state == mig_pkg::WR_IDLE) && !w_held;
  assign wr_commit = (wr_state == mig_pkg::WR_IDLE) && aw_held && w_held;
  assign wr_hit = reg_hit(aw_addr);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held <= 1'b0;
    end
  end

  // ----------------------------------------
  // write response
  // ----------------------------------------
  // bresp is latched with the state so it stands until bready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_state <= mig_pkg::WR_IDLE;
      s_axi_bresp <= mig_pkg::RESP_OKAY;
    end else begin
      unique case (wr_state)
        mig_pkg::WR_IDLE: begin
          if (wr_commit) begin
            wr_state <= mig_pkg::WR_RESP;
            s_axi_bresp <= (|wr_hit) ? mig_pkg::RESP_OKAY : mig_pkg::RESP_SLVERR;
          end
        end
        mig_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= mig_pkg::WR_IDLE;
          end
        end
        // an illegal one-hot code falls back to idle rather than locking the bus
        default: begin
          wr_state <= mig_pkg::WR_IDLE;
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state == mig_pkg::WR_RESP);

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // the clear bit never stores; it only fires a one-cycle pulse
  always_comb begin
    next_ctrl = merge(ctrl, w_data, w_strb);
    next_ctrl[mig_pkg::CTRL_CLR_BIT] = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= mig_pkg::CTRL_RESET;
    end else if (wr_commit && wr_hit[0]) begin
      ctrl <= next_ctrl;
    end
  end

  // RULE15 software clear pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clr_pulse <= 1'b0;
    end else begin
      clr_pulse <= wr_commit && wr_hit[0] && w_strb[0] && w_data[mig_pkg::CTRL_CLR_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_word <= mig_pkg::CONFIG_RESET;
    end else if (wr_commit && wr_hit[1]) begin
      config_word <= merge(config_word, w_data, w_strb);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swin <= mig_pkg::SWIN_RESET;
    end else if (wr_commit && wr_hit[2]) begin
      swin <= merge(swin, w_data, w_strb);
    end
  end

  // ----------------------------------------
  // read side
  // ----------------------------------------
  // decode uses the live address; arready is high only in idle
  assign rd_hit = reg_hit(s_axi_araddr);

  // status is live, so a read shows the outputs of the cycle the address is taken
  always_comb begin
    status_word = '0;
    status_word[mig_pkg::ST_RESULT_BIT] = result;
    status_word[mig_pkg::ST_ECHO_BIT] = enable_echo;
    status_word[mig_pkg::ST_CNT_BAD_BIT] = count_bad;
    status_word[mig_pkg::ST_SEL_BAD_BIT] = sel_bad;
  end

  // unused bits of config, swin and inputs read back as zero; ctrl reads back as stored
  always_comb begin
    rd_word = '0;
    unique case (1'b1)
      rd_hit[0]: rd_word = ctrl;
      rd_hit[1]: rd_word = {{(32 - mig_pkg::CFG_CNT_LSB - mig_pkg::CFG_CNT_W){1'b0}},
                            config_word[mig_pkg::CFG_CNT_LSB + mig_pkg::CFG_CNT_W - 1:0]};
      rd_hit[2]: rd_word = {{(32 - N){1'b0}}, swin[N-1:0]};
      rd_hit[3]: rd_word = status_word;
      rd_hit[4]: rd_word = {{(32 - N){1'b0}}, applied};
      default: rd_word = '0;
    endcase
  end

  assign s_axi_arready = (rd_state == mig_pkg::RD_IDLE);
  assign s_axi_rvalid = (rd_state == mig_pkg::RD_DATA);

  // read data are latched at the address handshake so they stand until rready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_state <= mig_pkg::RD_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= mig_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state)
        mig_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state <= mig_pkg::RD_DATA;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (|rd_hit) ? mig_pkg::RESP_OKAY : mig_pkg::RESP_SLVERR;
          end
        end
        mig_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rd_state <= mig_pkg::RD_IDLE;
          end
        end
        // an illegal one-hot code falls back to idle rather than locking the bus
        default: begin
          rd_state <= mig_pkg::RD_IDLE;
        end
      endcase
    end
  end

endmodule : mig_core

/* bench/mig_ctl_model.sv */
// controller model: drives the gate inputs on the bench's request
// assumes load is a one-cycle request from the bench
`timescale 1ns/100ps
module mig_ctl_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the bench
  input wire logic load,
  input wire logic [13:0] value,
  // gate inputs
  output logic [13:0] logic_input
);
  // inputs change only at a rising clock edge, never mid-cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      logic_input <= 14'h0000;
    end else if (load) begin
      logic_input <= value;
    end
  end
endmodule : mig_ctl_model

/* bench/mig_chk_chk.sv */
// checker: gate outputs against a shadow of ctrl and config
// assumes address and data are offered together with full strobes
`timescale 1ns/100ps
module mig_chk #(
  parameter int ADDR_W = 8,
  parameter int N = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register writes
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // gate
  input wire logic [N-1:0] logic_input,
  input wire logic result,
  input wire logic enable_echo
);
  logic pend, en, src, h_en, h_a, h_o, h_x, clr, run, calm;
  logic [ADDR_W-1:0] pa;
  logic [31:0] pd;
  logic [11:0] cfg;
  logic [N-1:0] mk, sw, iv;
  logic [7:0] h_sel;
  logic [2:0] quiet;
  assign clr = pend && pa == ADDR_W'(mig_pkg::OFF_CTRL) && pd[2];
  assign calm = quiet == 3'h0;
  assign run = calm && h_en;
  // the gate sees the software inputs when the source bit is set
  assign iv = src ? sw : logic_input;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      mk[i] = i < int'(cfg[11:8]);
    end
  end
  always_ff @(posedge clk) begin
    pa <= s_axi_awaddr;
    pd <= s_axi_wdata;
  end
  // shadow lags the design by one edge, as the outputs do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      en <= 1'b0;
      src <= 1'b0;
      sw <= '0;
      cfg <= 12'h200;
      quiet <= 3'h0;
      h_en <= 1'b0;
      h_sel <= 8'h00;
      h_a <= 1'b0;
      h_o <= 1'b0;
      h_x <= 1'b0;
    end else begin
      pend <= s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
      if (pend && pa == ADDR_W'(mig_pkg::OFF_CTRL)) en <= pd[0];
      if (pend && pa == ADDR_W'(mig_pkg::OFF_CTRL)) src <= pd[1];
      if (pend && pa == ADDR_W'(mig_pkg::OFF_SWIN)) sw <= pd[N-1:0];
      if (pend && pa == ADDR_W'(mig_pkg::OFF_CONFIG)) cfg <= pd[11:0];
      if (clr) quiet <= 3'h5;
      else if (!calm) quiet <= quiet - 3'h1;
      h_en <= en;
      h_sel <= cfg[7:0];
      h_a <= &(iv | ~mk);
      h_o <= |(iv & mk);
      h_x <= ^(iv & mk);
    end
  end
  // ----------------------------------------
  // gate properties
  // ----------------------------------------
  property p_and;
    @(posedge clk) disable iff (rst) run && h_sel == 8'h00 |-> result == h_a;
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_or;
    @(posedge clk) disable iff (rst) run && h_sel == 8'h01 |-> result == h_o;
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");
  property p_xor;
    @(posedge clk) disable iff (rst) run && h_sel == 8'h02 |-> result == h_x;
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");
  property p_inv;
    @(posedge clk) disable iff (rst) run && h_sel inside {[8'h03:8'h05]}
      |-> result != (h_sel == 8'h03 ? h_a : h_sel == 8'h04 ? h_o : h_x);
  endproperty
  a_inv: assert property (p_inv) else $error("inverted result wrong");
  property p_off;
    @(posedge clk) disable iff (rst) calm && !h_en |-> !result;
  endproperty
  a_off: assert property (p_off) else $error("result high while disabled");
  property p_bad;
    @(posedge clk) disable iff (rst) calm && h_sel > 8'h05 |-> !result && !enable_echo;
  endproperty
  a_bad: assert property (p_bad) else $error("outputs high on bad selector");
  property p_echo;
    @(posedge clk) disable iff (rst) calm && h_sel <= 8'h05 |-> enable_echo == h_en;
  endproperty
  a_echo: assert property (p_echo) else $error("echo differs from enable");
  property p_clr;
    @(posedge clk) disable iff (rst) clr |-> ##[1:4] (!result && !enable_echo);
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not zero outputs");
endmodule : mig_chk

bind mig_core mig_chk #(.ADDR_W(ADDR_W), .N(N)) u_chk (.clk(clk), .rst(rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .logic_input(logic_input), .result(result), .enable_echo(enable_echo));

/* bench/multi_input_logic_gate_tb.sv */
// testbench: registers over axi4-lite, gate functions, clear and error paths
// assumes the controller model supplies the gate inputs
`timescale 1ns/100ps
module multi_input_logic_gate_tb;
  localparam logic [3:0] CN [6] = '{4'h2, 4'h2, 4'h4, 4'he, 4'he, 4'h2};
  localparam logic [13:0] PV [6] = '{14'h0001, 14'h3ffc, 14'h000c, 14'h3fff, 14'h1fff, 14'h0003};
  logic clk, rst, aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v, res, echo, ld;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, rdv;
  logic [1:0] b_resp, r_resp, rsp;
  logic [13:0] gin, gval;
  int n_mismatch, comparisons;

  mig_core dut (.clk(clk), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .logic_input(gin), .result(res), .enable_echo(echo));
  mig_ctl_model ctl (.clk(clk), .rst(rst), .load(ld), .value(gval), .logic_input(gin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    tb = 1'b0;
    // ready is read at the falling edge so the rising edge is never raced
    while (!tb) begin
      @(negedge clk);
      ta = aw_v && aw_rdy;
      tw = w_v && w_rdy;
      tb = b_v;
      rsp = b_resp;
      @(posedge clk);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
    end
    b_r <= 1'b0;
    check(32'(rsp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = ar_v && ar_rdy;
      tr = r_v;
      rdv = r_d;
      rsp = r_resp;
      @(posedge clk);
      if (ta) ar_v <= 1'b0;
    end
    r_r <= 1'b0;
    check(rdv, ed);
    check(32'(rsp), 32'(er));
  endtask : rd

  task automatic gate(input logic [13:0] v, input logic er, input logic ee);
    @(posedge clk);
    gval <= v;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(32'(res), 32'(er));
    check(32'(echo), 32'(ee));
  endtask : gate

  function automatic logic gexp(input logic [7:0] s, input logic [3:0] c, input logic [13:0] v);
    logic [13:0] mk;
    for (int i = 0; i < 14; i++) mk[i] = i < int'(c);
    case (s)
      8'h00: return &(v | ~mk);
      8'h01: return |(v & mk);
      8'h02: return ^(v & mk);
      8'h03: return !(&(v | ~mk));
      8'h04: return !(|(v & mk));
      8'h05: return !(^(v & mk));
      default: return 1'b0;
    endcase
  endfunction : gexp

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset;
    rd(mig_pkg::OFF_CTRL, 32'h0, mig_pkg::RESP_OKAY);
    rd(mig_pkg::OFF_CONFIG, 32'h200, mig_pkg::RESP_OKAY);
    gate(14'h3fff, 1'b0, 1'b0);
  endtask : s_reset

  task automatic s_functions;
    wr(mig_pkg::OFF_CTRL, 32'h1, mig_pkg::RESP_OKAY);
    for (int s = 0; s < 6; s++) begin
      for (int t = 0; t < 6; t++) begin
        wr(mig_pkg::OFF_CONFIG, {20'h0, CN[t], 8'(s)}, mig_pkg::RESP_OKAY);
        gate(PV[t], gexp(8'(s), CN[t], PV[t]), 1'b1);
      end
    end
  endtask : s_functions

  task automatic s_disable;
    wr(mig_pkg::OFF_CONFIG, 32'he01, mig_pkg::RESP_OKAY);
    wr(mig_pkg::OFF_CTRL, 32'h0, mig_pkg::RESP_OKAY);
    gate(14'h3fff, 1'b0, 1'b0);
    wr(mig_pkg::OFF_CTRL, 32'h1, mig_pkg::RESP_OKAY);
  endtask : s_disable

  task automatic s_badsel;
    wr(mig_pkg::OFF_CONFIG, 32'hffff_feff, mig_pkg::RESP_OKAY);
    rd(mig_pkg::OFF_CONFIG, 32'heff, mig_pkg::RESP_OKAY);
    gate(14'h3fff, 1'b0, 1'b0);
    rd(mig_pkg::OFF_STATUS, 32'h8, mig_pkg::RESP_OKAY);
    wr(mig_pkg::OFF_CONFIG, 32'he06, mig_pkg::RESP_OKAY);
    gate(14'h0000, 1'b0, 1'b0);
    wr(mig_pkg::OFF_CONFIG, 32'he05, mig_pkg::RESP_OKAY);
    gate(14'h3fff, 1'b1, 1'b1);
  endtask : s_badsel

  task automatic s_clear_errors;
    wr(mig_pkg::OFF_CONFIG, 32'he01, mig_pkg::RESP_OKAY);
    wr(mig_pkg::OFF_CTRL, 32'h5, mig_pkg::RESP_OKAY);
    rd(mig_pkg::OFF_CTRL, 32'h1, mig_pkg::RESP_OKAY);
    gate(14'h3fff, 1'b1, 1'b1);
    wr(8'h14, 32'h1, mig_pkg::RESP_SLVERR);
    rd(8'h14, 32'h0, mig_pkg::RESP_SLVERR);
    wr(mig_pkg::OFF_STATUS, 32'hf, mig_pkg::RESP_OKAY);
    rd(mig_pkg::OFF_STATUS, 32'h3, mig_pkg::RESP_OKAY);
    rd(mig_pkg::OFF_INPUTS, 32'h3fff, mig_pkg::RESP_OKAY);
    wr(mig_pkg::OFF_SWIN, 32'hffff_ffff, mig_pkg::RESP_OKAY);
    rd(mig_pkg::OFF_SWIN, 32'h3fff, mig_pkg::RESP_OKAY);
    wr(mig_pkg::OFF_CONFIG, 32'he00, mig_pkg::RESP_OKAY);
    wr(mig_pkg::OFF_SWIN, 32'h3ffe, mig_pkg::RESP_OKAY);
    wr(mig_pkg::OFF_CTRL, 32'h3, mig_pkg::RESP_OKAY);
    rd(mig_pkg::OFF_INPUTS, 32'h3ffe, mig_pkg::RESP_OKAY);
    gate(14'h3fff, 1'b0, 1'b1);
    wr(mig_pkg::OFF_CTRL, 32'h1, mig_pkg::RESP_OKAY);
  endtask : s_clear_errors

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst = 1'b1;
    {aw_v, w_v, b_r, ar_v, r_r, ld} = 6'h00;
    {aw_a, ar_a, w_d, gval} = 62'h0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_functions();
    s_disable();
    s_badsel();
    s_clear_errors();
    report_and_stop();
  end

  // a hang costs one mismatch; the whole run needs about 500 cycles
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : multi_input_logic_gate_tb
